// *** core/pwmg_core.sv ***
// PWM generator with control, extension and duty registers.
// Assumes a plain register port on the oscillator clock, synchronous
// active-high reset and a clock enable that freezes all state.
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps

// What this block does
// - Counter clock is oscillator divided 64/8/2/1
// - Duty reloads on extension or base overflow
// - Writing one to clear bit zeroes counter
// - Clear bit keeps written value, never self-clears
// - Counter advances only while enable bit set
// - Overflow interrupt forwarded only when enabled
// - Pending reads state, write zero clears it
// - Modes 00/10 split primary duty six plus two
// - Mode 01 secondary six plus extension six
// - Mode 11 secondary eight plus extension six
// - Upper extension bits ignored in 6+2 mode
// - Control and extension registers reset to zero
module pwmg_core (
  input  wire logic       clock,    // Oscillator clock, 20 MHz
  input  wire logic       ce,       // Clock enable
  input  wire logic       rst,      // Synchronous reset
  input  wire logic [7:0] addr,     // Register address
  input  wire logic [7:0] wr_data,  // Write data
  input  wire logic       wr_en,    // Write strobe
  input  wire logic       rd_en,    // Read strobe
  output logic      [7:0] rd_data,  // Read data, cycle after strobe
  output logic            pwm_out,  // PWM waveform
  output logic            irq       // Level interrupt
);
  import pwmg_pkg::*;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  // Base counter limit for a resolution mode
  function automatic logic [7:0] base_top(input logic [1:0] mode);
    base_top = (mode == RES_86) ? BASE8_TOP : BASE6_TOP;
  endfunction
  // Extension counter limit for a resolution mode
  function automatic logic [5:0] ext_top(input logic [1:0] mode);
    ext_top = mode[0] ? EXT6_TOP : EXT2_TOP;
  endfunction

  // ----------------------------------------------------------------------
  // Registers and internal signals
  // ----------------------------------------------------------------------
  logic [1:0]       clk_sel_r;    // Counter clock select
  logic             reload_sel_r; // Reload on base overflow when set
  logic             clear_bit_r;  // Stored counter clear bit
  logic             run_r;        // Counter enable
  logic             ovf_ie_r;     // Overflow interrupt enable
  logic             ovf_pend_r;   // Overflow pending
  logic             ovf_pend_nxt; // Next pending value
  logic [7:0]       ext_reg_r;    // Extension control register
  logic [7:0]       pri_duty_r;   // Primary duty register
  logic [7:0]       sec_duty_r;   // Secondary duty register
  logic [EVT_W-1:0] evt_stat_r;   // Sticky event status
  logic [EVT_W-1:0] evt_stat_nxt; // Next event status
  logic [EVT_W-1:0] evt_mask_r;   // Event mask
  logic [EVT_W-1:0] evt_now;      // Events in this cycle
  logic [7:0]       base_cnt_r;   // Base up counter
  logic [5:0]       ext_cnt_r;    // Extension up counter
  logic [7:0]       base_duty_r;  // Latched base duty
  logic [5:0]       ext_duty_r;   // Latched extension duty
  logic [7:0]       base_duty_nxt;// Base duty from registers
  logic [5:0]       ext_duty_nxt; // Extension duty from registers
  logic [7:0]       rd_data_r;    // Registered read data
  logic [7:0]       rd_mux;       // Read data selection
  logic [7:0]       ctrl_view;    // Control register as read
  logic             pwm_out_r;    // Registered waveform
  logic             pwm_nxt;      // Next waveform level
  logic [1:0]       mode;         // Resolution mode
  logic             tick;         // Prescaler tick
  logic             step;         // Counter advances
  logic             base_ovf;     // Base counter wraps
  logic             ext_ovf;      // Extension counter wraps
  logic             reload;       // Reload point while running
  logic             load_duty;    // Duty latch loads
  logic             wr_ctrl;      // Write to control
  logic             clear_req;    // Counter clear request

  // ----------------------------------------------------------------------
  // Counter clock
  // ----------------------------------------------------------------------
  // prescaled counter clock
  pwmg_prescaler u_prescaler (
    .clock   (clock),
    .ce      (ce),
    .rst     (rst),
    .clk_sel (clk_sel_r),
    .tick    (tick)
  );

  // ----------------------------------------------------------------------
  // Counter control decode
  // ----------------------------------------------------------------------
  assign mode      = ext_reg_r[1:0];
  assign wr_ctrl   = ce && wr_en && (addr == ADDR_CTRL);
  assign clear_req = wr_ctrl && wr_data[CTL_CLEAR_BIT];
  assign step      = tick && run_r;
  assign base_ovf  = step && (base_cnt_r == base_top(mode));
  assign ext_ovf   = base_ovf && (ext_cnt_r == ext_top(mode));
  assign reload    = reload_sel_r ? base_ovf : ext_ovf;
  // Duty follows the registers while stopped
  assign load_duty = ce && (!run_r || reload);

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  // zero control after reset
  always_ff @(posedge clock) begin
    if (rst) begin
      clk_sel_r    <= CTL_RESET[CTL_CLKSEL_LSB +: 2];
      reload_sel_r <= CTL_RESET[CTL_RELOAD_BIT];
      clear_bit_r  <= CTL_RESET[CTL_CLEAR_BIT];
      run_r        <= CTL_RESET[CTL_RUN_BIT];
      ovf_ie_r     <= CTL_RESET[CTL_IE_BIT];
    end else if (wr_ctrl) begin
      clk_sel_r    <= wr_data[CTL_CLKSEL_LSB +: 2];
      reload_sel_r <= wr_data[CTL_RELOAD_BIT];
      // clear bit only changes by write
      clear_bit_r  <= wr_data[CTL_CLEAR_BIT];
      run_r        <= wr_data[CTL_RUN_BIT];
      ovf_ie_r     <= wr_data[CTL_IE_BIT];
    end
  end

  // Pending bit: hardware set wins over a clearing write
  always_comb begin
    ovf_pend_nxt = ovf_pend_r;
    if (wr_ctrl && !wr_data[CTL_PEND_BIT]) begin
      ovf_pend_nxt = 1'b0;
    end
    if (base_ovf) begin
      ovf_pend_nxt = 1'b1;
    end
  end

  // Pending flop
  always_ff @(posedge clock) begin
    if (rst) begin
      ovf_pend_r <= CTL_RESET[CTL_PEND_BIT];
    end else if (ce) begin
      ovf_pend_r <= ovf_pend_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Extension and duty registers
  // ----------------------------------------------------------------------
  // Register writes
  always_ff @(posedge clock) begin
    if (rst) begin
      ext_reg_r  <= EXT_RESET;
      pri_duty_r <= DUTY_RESET;
      sec_duty_r <= DUTY_RESET;
    end else if (ce && wr_en) begin
      case (addr)
        ADDR_EXT:      ext_reg_r  <= wr_data;
        ADDR_PRI_DUTY: pri_duty_r <= wr_data;
        ADDR_SEC_DUTY: sec_duty_r <= wr_data;
        default:       ;
      endcase
    end
  end

  // Split duty into base and extension by mode
  always_comb begin
    case (mode)
      RES_66: begin
        base_duty_nxt = {2'b00, sec_duty_r[5:0]};
        ext_duty_nxt  = ext_reg_r[7:EXT_VAL_LSB];
      end
      RES_86: begin
        base_duty_nxt = sec_duty_r;
        ext_duty_nxt  = ext_reg_r[7:EXT_VAL_LSB];
      end
      default: begin
        base_duty_nxt = {2'b00, pri_duty_r[7:2]};
        ext_duty_nxt  = {4'h0, pri_duty_r[1:0]};
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      base_duty_r <= DUTY_RESET;
      ext_duty_r  <= DUTY_RESET[5:0];
    end else if (load_duty) begin
      base_duty_r <= base_duty_nxt;
      ext_duty_r  <= ext_duty_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------------
  // clear beats counting
  always_ff @(posedge clock) begin
    if (rst) begin
      base_cnt_r <= 8'h00;
      ext_cnt_r  <= 6'h00;
    end else if (clear_req) begin
      base_cnt_r <= 8'h00;
      ext_cnt_r  <= 6'h00;
    end else if (ce && step) begin
      base_cnt_r <= base_ovf ? 8'h00 : base_cnt_r + 8'h01;
      if (ext_ovf) begin
        ext_cnt_r <= 6'h00;
      end else if (base_ovf) begin
        ext_cnt_r <= ext_cnt_r + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Waveform
  // ----------------------------------------------------------------------
  // compare with stretch
  always_comb begin
    pwm_nxt = (base_cnt_r < base_duty_r) ||
              ((base_cnt_r == base_duty_r) && (ext_cnt_r < ext_duty_r));
  end

  // Output flop
  always_ff @(posedge clock) begin
    if (rst) begin
      pwm_out_r <= 1'b0;
    end else if (ce) begin
      pwm_out_r <= pwm_nxt;
    end
  end
  assign pwm_out = pwm_out_r;

  // ----------------------------------------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------------------------------------
  assign evt_now = {reload && run_r, ext_ovf, base_ovf};
  // Sticky status, write one clears, set wins
  always_comb begin
    evt_stat_nxt = evt_stat_r;
    if (wr_en && addr == ADDR_EVT_STAT) begin
      evt_stat_nxt = evt_stat_r & ~wr_data[EVT_W-1:0];
    end
    evt_stat_nxt = evt_stat_nxt | evt_now;
  end

  // Status and mask flops
  always_ff @(posedge clock) begin
    if (rst) begin
      evt_stat_r <= EVT_RESET;
      evt_mask_r <= EVT_RESET;
    end else if (ce) begin
      evt_stat_r <= evt_stat_nxt;
      if (wr_en && addr == ADDR_EVT_MASK) begin
        evt_mask_r <= wr_data[EVT_W-1:0];
      end
    end
  end
  assign irq = (ovf_pend_r && ovf_ie_r) || |(evt_stat_r & evt_mask_r);

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  // Unused bit five reads zero
  assign ctrl_view = {clk_sel_r, 1'b0, reload_sel_r, clear_bit_r,
                      run_r, ovf_ie_r, ovf_pend_r};

  // Read selection, unmapped reads zero
  always_comb begin
    case (addr)
      ADDR_CTRL:     rd_mux = ctrl_view;
      ADDR_EXT:      rd_mux = ext_reg_r;
      ADDR_PRI_DUTY: rd_mux = pri_duty_r;
      ADDR_SEC_DUTY: rd_mux = sec_duty_r;
      ADDR_EVT_STAT: rd_mux = {5'h00, evt_stat_r};
      ADDR_EVT_MASK: rd_mux = {5'h00, evt_mask_r};
      default:       rd_mux = 8'h00;
    endcase
  end
  // Read data for one cycle only
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data_r <= 8'h00;
    end else if (ce) begin
      rd_data_r <= rd_en ? rd_mux : 8'h00;
    end
  end
  assign rd_data = rd_data_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // clear zeroes counters
  a_clear_zeroes_cnt: assert property (
    @(posedge clock) disable iff (rst)
    clear_req |=> (base_cnt_r == 8'h00) && (ext_cnt_r == 6'h00))
    else $error("Counter not zero after clear write");
  a_clear_bit_held: assert property (
    @(posedge clock) disable iff (rst)
    !wr_ctrl |=> $stable(clear_bit_r))
    else $error("Clear bit changed without a write");
  a_stop_holds_cnt: assert property (
    @(posedge clock) disable iff (rst)
    (!run_r && !clear_req) |=> $stable(base_cnt_r) && $stable(ext_cnt_r))
    else $error("Stopped counter moved");
  a_irq_gated: assert property (
    @(posedge clock) disable iff (rst)
    (!ovf_ie_r && (evt_stat_r & evt_mask_r) == 3'h0) |-> !irq)
    else $error("Interrupt raised while disabled");
  a_pend_w1_noop: assert property (
    @(posedge clock) disable iff (rst)
    (wr_ctrl && wr_data[CTL_PEND_BIT] && !ovf_pend_r && !base_ovf)
    |=> !ovf_pend_r)
    else $error("Writing one set the pending bit");
  a_ovf_sets_pend: assert property (
    @(posedge clock) disable iff (rst)
    base_ovf |=> ovf_pend_r && irq == (ovf_ie_r || |(evt_stat_r & evt_mask_r)))
    else $error("Overflow did not set pending");
  a_reload_points: assert property (
    @(posedge clock) disable iff (rst)
    (ce && run_r && !reload) |=> $stable(base_duty_r) && $stable(ext_duty_r))
    else $error("Duty reloaded off the reload point");
  a_mode_62_split: assert property (
    @(posedge clock) disable iff (rst)
    (load_duty && !mode[0]) |=> base_duty_r == {2'b00, $past(pri_duty_r[7:2])}
    && ext_duty_r == {4'h0, $past(pri_duty_r[1:0])})
    else $error("Six plus two split wrong");
  a_mode_86_split: assert property (
    @(posedge clock) disable iff (rst)
    (load_duty && mode == RES_86) |=> base_duty_r == $past(sec_duty_r)
    && ext_duty_r == $past(ext_reg_r[7:2]))
    else $error("Eight plus six split wrong");
  a_reset_zero: assert property (
    @(posedge clock) disable iff (rst)
    $past(rst) |-> ctrl_view == CTL_RESET && ext_reg_r == EXT_RESET)
    else $error("Control not zero after reset");
  a_pwm_below_duty: assert property (
    @(posedge clock) disable iff (rst)
    (ce && base_cnt_r < base_duty_r) |=> pwm_out)
    else $error("Output low below duty");

endmodule // pwmg_core

// *** core/pwmg_prescaler.sv ***
// Prescaler that turns the oscillator clock into counter ticks.
// Assumes one clock, a synchronous active-high reset and a clock enable.
`timescale 1ns/1ps

module pwmg_prescaler (
  input  wire logic       clock,   // Oscillator clock
  input  wire logic       ce,      // Clock enable, freezes state
  input  wire logic       rst,     // Synchronous reset
  input  wire logic [1:0] clk_sel, // Division select
  output logic            tick     // One-cycle counter tick
);
  import pwmg_pkg::*;

  // ----------------------------------------------------------------------
  // Free-running divider
  // ----------------------------------------------------------------------
  logic [5:0] div_cnt_r; // Divider count
  logic [5:0] mask;      // Terminal mask for the selected ratio

  // Mask select
  always_comb begin
    case (clk_sel)
      CLK_DIV64: mask = PRE_MASK64;
      CLK_DIV8:  mask = PRE_MASK8;
      CLK_DIV2:  mask = PRE_MASK2;
      default:   mask = PRE_MASK1;
    endcase
  end

  // Divider advances every enabled cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      div_cnt_r <= PRE_RESET;
    end else if (ce) begin
      div_cnt_r <= div_cnt_r + 6'h01;
    end
  end

  assign tick = ce && ((div_cnt_r & mask) == mask);

  a_div1_every_cycle: assert property (
    @(posedge clock) disable iff (rst)
    (ce && clk_sel == CLK_DIV1) |-> tick)
    else $error("Divide-by-one select did not tick");

  a_div2_spacing: assert property (
    @(posedge clock) disable iff (rst)
    (tick && clk_sel == CLK_DIV2) ##1 (ce && clk_sel == CLK_DIV2) |-> !tick)
    else $error("Divide-by-two ticks came back to back");

endmodule // pwmg_prescaler

// *** inc/pwmg_pkg.sv ***
// Constants for the PWM generator: register addresses, field positions,
// reset values and counter limits.
// Assumes an 8-bit register address space reached over a plain port.

package pwmg_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_SEC_DUTY  = 8'hf0; // Secondary duty register
  localparam logic [7:0] ADDR_EXT       = 8'hf1; // Extension control
  localparam logic [7:0] ADDR_PRI_DUTY  = 8'hf2; // Primary duty register
  localparam logic [7:0] ADDR_CTRL      = 8'hf3; // PWM control
  localparam logic [7:0] ADDR_EVT_STAT  = 8'hf4; // Event status, W1C
  localparam logic [7:0] ADDR_EVT_MASK  = 8'hf5; // Event mask

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int CTL_CLKSEL_LSB = 6; // Two-bit clock select
  localparam int CTL_UNUSED_BIT = 5; // No function, reads zero
  localparam int CTL_RELOAD_BIT = 4; // Reload interval select
  localparam int CTL_CLEAR_BIT  = 3; // Counter clear
  localparam int CTL_RUN_BIT    = 2; // Counter enable
  localparam int CTL_IE_BIT     = 1; // Overflow interrupt enable
  localparam int CTL_PEND_BIT   = 0; // Overflow pending

  // Clock select codes
  localparam logic [1:0] CLK_DIV64 = 2'b00;
  localparam logic [1:0] CLK_DIV8  = 2'b01;
  localparam logic [1:0] CLK_DIV2  = 2'b10;
  localparam logic [1:0] CLK_DIV1  = 2'b11;

  // Prescaler terminal masks, one per clock select
  localparam logic [5:0] PRE_MASK64 = 6'h3f;
  localparam logic [5:0] PRE_MASK8  = 6'h07;
  localparam logic [5:0] PRE_MASK2  = 6'h01;
  localparam logic [5:0] PRE_MASK1  = 6'h00;

  // ----------------------------------------------------------------------
  // Extension register fields and resolution modes
  // ----------------------------------------------------------------------
  localparam int         EXT_VAL_LSB = 2;     // Six-bit extension value
  localparam logic [1:0] RES_62A     = 2'b00; // 6+2 resolution
  localparam logic [1:0] RES_66      = 2'b01; // 6+6 resolution
  localparam logic [1:0] RES_62B     = 2'b10; // 6+2 resolution, alias
  localparam logic [1:0] RES_86      = 2'b11; // 8+6 resolution

  // Counter limits
  localparam logic [7:0] BASE6_TOP = 8'h3f;
  localparam logic [7:0] BASE8_TOP = 8'hff;
  localparam logic [5:0] EXT2_TOP  = 6'h03;
  localparam logic [5:0] EXT6_TOP  = 6'h3f;

  // ----------------------------------------------------------------------
  // Events and reset values
  // ----------------------------------------------------------------------
  localparam int EVT_BASE_OVF = 0; // Base counter overflow
  localparam int EVT_EXT_OVF  = 1; // Extension counter overflow
  localparam int EVT_RELOAD   = 2; // Duty reloaded while running
  localparam int EVT_W        = 3;

  localparam logic [7:0]       CTL_RESET  = 8'h00;
  localparam logic [7:0]       EXT_RESET  = 8'h00;
  localparam logic [7:0]       DUTY_RESET = 8'h00;
  localparam logic [EVT_W-1:0] EVT_RESET  = 3'h0;
  localparam logic [5:0]       PRE_RESET  = 6'h00;

endpackage

// *** verif/test_pwm_generator_control.sv ***
// Testbench for the PWM generator core: register access, duty counts
// per mode and divider, overflow pending, event flags and interrupt.
// Assumes the core's plain register port and the pwmg_pkg addresses.
`timescale 1ns/1ps

module test_pwm_generator_control;
  import pwmg_pkg::*;

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic       clock   = 1'b0;  // 20 MHz oscillator
  logic       ce      = 1'b1;  // Clock enable
  logic       rst     = 1'b1;  // Synchronous reset
  logic [7:0] addr    = 8'h00; // Register address
  logic [7:0] wr_data = 8'h00; // Write data
  logic       wr_en   = 1'b0;  // Write strobe
  logic       rd_en   = 1'b0;  // Read strobe
  logic [7:0] rd_data;         // Read data
  logic       pwm_out;         // Waveform
  logic       irq;             // Interrupt
  int         n_mismatch = 0;  // Mismatches seen
  int         cmp_count  = 0;  // Comparisons made

  // Waveform case: control, extension, duties, window, high count
  typedef struct packed {
    logic [7:0] ctl, ext, pri, sec;
    int         per, hi;
  } pgc_case_s;

  // Dividers 1/2/8/64 and all four resolution codes
  pgc_case_s cases [6] = '{
    '{8'hcc, 8'hfc, 8'h52, 8'hff, 256, 82},
    '{8'h9c, 8'h02, 8'h0b, 8'hff, 512, 22},
    '{8'h4c, 8'h00, 8'hff, 8'hff, 2048, 2040},
    '{8'h0c, 8'h00, 8'h01, 8'hff, 16384, 64},
    '{8'hcc, 8'h15, 8'hff, 8'hca, 4096, 645},
    '{8'hcc, 8'hff, 8'hff, 8'h80, 16384, 8255}
  };

  // Clock, 50 ns period
  always #25 clock = ~clock;

  // Device under test
  pwmg_core uut (
    .clock   (clock),
    .ce      (ce),
    .rst     (rst),
    .addr    (addr),
    .wr_data (wr_data),
    .wr_en   (wr_en),
    .rd_en   (rd_en),
    .rd_data (rd_data),
    .pwm_out (pwm_out),
    .irq     (irq)
  );

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // One-cycle write, settles past the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    #1;
  endtask

  // One-cycle read, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string nm);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk(nm, exp, rd_data);
  endtask

  // Count high cycles of the waveform over a window
  task automatic meas(input int per, input int hi);
    logic [31:0] n;
    n = 0;
    repeat (per) begin
      @(posedge clock);
      #1;
      if (pwm_out === 1'b1) n++;
    end
    chk("high count", hi, n);
  endtask

  // Verdict and end of run
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    #4900000;
    n_mismatch++;
    end_of_test();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    // Every register reads zero after reset
    for (int a = 0; a < 6; a++) begin
      rd(ADDR_SEC_DUTY + 8'(a), 8'h00, "reset value");
    end
    chk("irq reset", 0, irq);
    chk("pwm reset", 0, pwm_out);
    // Duty counts per divider and mode; bit five always written zero
    foreach (cases[i]) begin
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_EXT, cases[i].ext);
      wr(ADDR_PRI_DUTY, cases[i].pri);
      wr(ADDR_SEC_DUTY, cases[i].sec);
      rd(ADDR_EXT, cases[i].ext, "extension");
      wr(ADDR_CTRL, cases[i].ctl);
      rd(ADDR_CTRL, cases[i].ctl, "control");
      repeat (cases[i].per) @(posedge clock);
      meas(cases[i].per, cases[i].hi);
    end
    // Overflow pending and its interrupt enable
    wr(ADDR_CTRL, 8'hc4);
    repeat (300) @(posedge clock);
    rd(ADDR_CTRL, 8'hc5, "pending set");
    chk("irq disabled", 0, irq);
    wr(ADDR_CTRL, 8'hc7);
    rd(ADDR_CTRL, 8'hc7, "pending kept");
    chk("irq enabled", 1, irq);
    wr(ADDR_CTRL, 8'h02);
    rd(ADDR_CTRL, 8'h02, "pending clear");
    chk("irq cleared", 0, irq);
    wr(ADDR_CTRL, 8'h03);
    rd(ADDR_CTRL, 8'h02, "pending no set");
    // Event status, mask and write-one clear
    rd(ADDR_EVT_STAT, 8'h07, "event status");
    wr(ADDR_EVT_MASK, 8'h01);
    chk("irq event", 1, irq);
    wr(ADDR_EVT_STAT, 8'h01);
    rd(ADDR_EVT_STAT, 8'h06, "status clear");
    chk("irq event off", 0, irq);
    wr(ADDR_EVT_MASK, 8'h00);
    // Unmapped address
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00, "unmapped");
    // Halt, clear while stopped, output held high
    wr(ADDR_EXT, 8'h00);
    wr(ADDR_PRI_DUTY, 8'h04);
    wr(ADDR_CTRL, 8'hcc);
    repeat (30) @(posedge clock);
    wr(ADDR_CTRL, 8'hc0);
    meas(200, 0);
    wr(ADDR_CTRL, 8'hc8);
    @(posedge clock);
    meas(50, 50);
    rd(ADDR_CTRL, 8'hc8, "clear kept");
    // Write ignored while the clock enable is low
    @(posedge clock);
    ce <= 1'b0;
    wr(ADDR_CTRL, 8'h00);
    ce <= 1'b1;
    rd(ADDR_CTRL, 8'hc8, "ce held");
    wr(ADDR_CTRL, 8'hc4);
    meas(256, 4);
    // Second reset in mid-run
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(ADDR_CTRL, 8'h00, "reset again");
    chk("irq again", 0, irq);
    end_of_test();
  end

endmodule // test_pwm_generator_control
